// File: rtl/isfv_pkg.sv
// Constants shared by the interrupt controller files
package isfv_pkg;
    localparam int NUM_SRC = 11;
    localparam int SRC_W   = 4;
    // Source index in fixed polling rank order, 0 is ranked highest
    localparam logic [3:0] SRC_EXT_A    = 4'h0;
    localparam logic [3:0] SRC_BROWNOUT = 4'h1;
    localparam logic [3:0] SRC_WATCHDOG = 4'h2;
    localparam logic [3:0] SRC_TIMER_A  = 4'h3;
    localparam logic [3:0] SRC_TWOWIRE  = 4'h4;
    localparam logic [3:0] SRC_EXT_B    = 4'h5;
    localparam logic [3:0] SRC_KEYPAD   = 4'h6;
    localparam logic [3:0] SRC_TIMER_B  = 4'h7;
    localparam logic [3:0] SRC_UART     = 4'h8;
    localparam logic [3:0] SRC_TIMER_C  = 4'h9;
    localparam logic [3:0] SRC_CAPTURE  = 4'ha;
    // Vector addresses
    localparam logic [15:0] VEC_EXT_A    = 16'h0003;
    localparam logic [15:0] VEC_TIMER_A  = 16'h000b;
    localparam logic [15:0] VEC_EXT_B    = 16'h0013;
    localparam logic [15:0] VEC_TIMER_B  = 16'h001b;
    localparam logic [15:0] VEC_UART     = 16'h0023;
    localparam logic [15:0] VEC_BROWNOUT = 16'h002b;
    localparam logic [15:0] VEC_TWOWIRE  = 16'h0033;
    localparam logic [15:0] VEC_KEYPAD   = 16'h003b;
    localparam logic [15:0] VEC_TIMER_C  = 16'h0043;
    localparam logic [15:0] VEC_WATCHDOG = 16'h0053;
    localparam logic [15:0] VEC_CAPTURE  = 16'h006b;
    // Register field positions
    localparam int WATCHDOG_CONTROL_REG_IRQ_BIT  = 3;
    localparam int EIE_WDOG_BIT   = 4;
    localparam int EIE_BROWN_BIT  = 6;
    localparam int AUX_BROWN_BIT  = 5;
    // Trigger type encoding
    localparam logic TRIG_LEVEL = 1'b0;
    localparam logic TRIG_EDGE  = 1'b1;
    localparam logic [7:0] TWOWIRE_IDLE_CODE = 8'hf8;
    localparam int KEY_W = 8;
endpackage : isfv_pkg

// File: rtl/isfv_ext_pin.sv
// One external interrupt pin: synchroniser, edge/level detect, request flag
`timescale 1ns/1ps
`default_nettype none
module isfv_ext_pin
    import isfv_pkg::*;
(
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic srst,
    // Pin and machine-cycle enable
    input  wire logic pin_n,
    input  wire logic mc_en,
    input  wire logic trigger_type,
    // Flag control
    input  wire logic hw_clear,
    input  wire logic sw_clear,
    output logic      request_flag
);
    logic sync1;
    logic sync2;
    logic prev_sample;
    logic next_flag;
    logic next_prev;

    always_comb
    begin
        next_prev = prev_sample;
        next_flag = request_flag;
        if (mc_en)
            next_prev = sync2;
        if (trigger_type == TRIG_EDGE)
        begin
            if (hw_clear || sw_clear)
                next_flag = 1'b0;
            if (mc_en && prev_sample && !sync2)
                next_flag = 1'b1;
        end
        else
        begin
            // Level mode: flag follows the sampled pin, not hw cleared
            if (mc_en)
                next_flag = !sync2;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            sync1        <= 1'b1;
            sync2        <= 1'b1;
            prev_sample  <= 1'b1;
            request_flag <= 1'b0;
        end
        else
        begin
            sync1        <= pin_n;
            sync2        <= sync1;
            prev_sample  <= next_prev;
            request_flag <= next_flag;
        end
    end

    chk_edge_sets: assert property (@(posedge core_clk) disable iff (srst)
        mc_en && trigger_type == TRIG_EDGE && prev_sample && !sync2
        |=> request_flag)
        else $error("edge not flagged");
    chk_level_hold: assert property (@(posedge core_clk) disable iff (srst)
        mc_en && trigger_type == TRIG_LEVEL && !sync2
        |=> request_flag)
        else $error("level request dropped");
endmodule : isfv_ext_pin
`default_nettype wire

// File: rtl/isfv_ctrl.sv
// Interrupt flag collection, enable gating, priority and vector select
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Each external pin has a trigger bit: falling edge or low level.
// - Edge mode samples per machine cycle; high then low sets flag.
// - Edge-mode external flag clears when its routine is vectored.
// - Level mode keeps flag on vectoring; source holds pin low.
// - Level-mode pin still low after service raises another request.
// - Timer A/B overflow flags set, cleared by hardware on service.
// - Watchdog time-out sets control bit 3; enabled by ext bit 4.
// - Timer C flag set on overflow/match, never cleared by vectoring.
// - UART rx and tx flags share a vector; software clears both.
// - New two-wire state code sets flag; global and local enable gate.
// - Enabled keypad line press sets keypad flag; software clears.
// - Capture event sets capture flag; software clears only.
// - Brownout irq needs aux bit 5, ext bit 6 and global enable.
// - Fixed vector addresses per source.
// - Eleven sources with flag, enable, priority, vector; global enable.
// - Two priority bits give levels 0 (lowest) to 3 (highest).
// - Equal levels resolved by fixed polling rank.
// - Flags are held until cleared; only an untaken level-mode pin request is lost.
module isfv_ctrl
    import isfv_pkg::*;
#(
    parameter int MC_DIV = 4
)
(
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 srst,
    // External pins and trigger types
    input  wire logic                 ext_irq_pin_a,
    input  wire logic                 ext_irq_pin_b,
    input  wire logic                 ext_a_trigger_type,
    input  wire logic                 ext_b_trigger_type,
    // Peripheral events, one-cycle pulses
    input  wire logic                 timer_a_ovf,
    input  wire logic                 timer_b_ovf,
    input  wire logic                 timer_c_event,
    input  wire logic                 watchdog_timeout,
    input  wire logic                 uart_rx_event,
    input  wire logic                 uart_tx_event,
    input  wire logic                 twowire_new_state,
    input  wire logic [KEY_W-1:0]     keypad_press,
    input  wire logic                 capture_event,
    input  wire logic                 brownout_event,
    // Software flag clears, one bit per flag
    input  wire logic                 clr_ext_a,
    input  wire logic                 clr_ext_b,
    input  wire logic                 clr_timer_a,
    input  wire logic                 clr_timer_b,
    input  wire logic                 clr_timer_c,
    input  wire logic                 clr_watchdog,
    input  wire logic                 clr_uart_rx,
    input  wire logic                 clr_uart_tx,
    input  wire logic                 clr_twowire,
    input  wire logic                 clr_keypad,
    input  wire logic                 clr_capture,
    input  wire logic                 clr_brownout,
    // Enables and priorities
    input  wire logic                 global_irq_enable,
    input  wire logic [NUM_SRC-1:0]   src_enable,
    input  wire logic [KEY_W-1:0]     keypad_enable,
    input  wire logic                 brownout_irq_select,
    input  wire logic [2*NUM_SRC-1:0] src_priority,
    // CPU side
    input  wire logic                 cpu_poll_ok,
    input  wire logic                 cpu_reti,
    output logic                      irq_take,
    output logic [15:0]               irq_vector,
    output logic [SRC_W-1:0]          irq_source,
    output logic [1:0]                irq_level,
    output logic                      mc_tick,
    // Flag status
    output logic                      ext_a_request_flag,
    output logic                      ext_b_request_flag,
    output logic                      timer_a_overflow_flag,
    output logic                      timer_b_overflow_flag,
    output logic                      timer_c_event_flag,
    output logic                      watchdog_irq_flag,
    output logic                      uart_rx_done_flag,
    output logic                      uart_tx_done_flag,
    output logic                      twowire_irq_flag,
    output logic                      keyboard_irq_flag,
    output logic                      capture_irq_flag,
    output logic                      brownout_flag
);
    initial
    begin
        if (MC_DIV < 1 || MC_DIV > 255)
            $error("MC_DIV out of range");
    end

    function automatic logic [15:0] vec_of(input logic [3:0] s);
        unique case (s)
            SRC_EXT_A:    vec_of = VEC_EXT_A;
            SRC_BROWNOUT: vec_of = VEC_BROWNOUT;
            SRC_WATCHDOG: vec_of = VEC_WATCHDOG;
            SRC_TIMER_A:  vec_of = VEC_TIMER_A;
            SRC_TWOWIRE:  vec_of = VEC_TWOWIRE;
            SRC_EXT_B:    vec_of = VEC_EXT_B;
            SRC_KEYPAD:   vec_of = VEC_KEYPAD;
            SRC_TIMER_B:  vec_of = VEC_TIMER_B;
            SRC_UART:     vec_of = VEC_UART;
            SRC_TIMER_C:  vec_of = VEC_TIMER_C;
            SRC_CAPTURE:  vec_of = VEC_CAPTURE;
            default:      vec_of = 16'h0000;
        endcase
    endfunction

    // Set wins over clear for every hardware-set flag
    function automatic logic upd(input logic f, input logic s,
                                 input logic c);
        upd = s | (f & ~c);
    endfunction

    // Machine-cycle enable divider
    logic [7:0] mc_cnt;
    logic [7:0] next_mc_cnt;
    logic       next_mc_tick;

    always_comb
    begin
        next_mc_tick = (mc_cnt == 8'(MC_DIV - 1));
        next_mc_cnt  = next_mc_tick ? 8'h00 : mc_cnt + 8'h01;
    end

    // Source flags
    logic ta_flag, tb_flag, tc_flag, wd_flag, rx_flag, tx_flag;
    logic tw_flag, kb_flag, cp_flag, bo_flag;
    logic n_ta, n_tb, n_tc, n_wd, n_rx, n_tx, n_tw, n_kb, n_cp, n_bo;
    logic ea_flag, eb_flag;
    logic hw_clr_a, hw_clr_b;
    logic next_take;
    logic [3:0] next_src;
    logic [1:0] next_lvl;
    logic [NUM_SRC-1:0] req;

    always_comb
    begin
        hw_clr_a = irq_take && irq_source == SRC_EXT_A;
        hw_clr_b = irq_take && irq_source == SRC_EXT_B;
        n_ta = upd(ta_flag, timer_a_ovf, clr_timer_a ||
                   (irq_take && irq_source == SRC_TIMER_A));
        n_tb = upd(tb_flag, timer_b_ovf, clr_timer_b ||
                   (irq_take && irq_source == SRC_TIMER_B));
        n_tc = upd(tc_flag, timer_c_event, clr_timer_c);
        n_wd = upd(wd_flag, watchdog_timeout, clr_watchdog);
        n_rx = upd(rx_flag, uart_rx_event, clr_uart_rx);
        n_tx = upd(tx_flag, uart_tx_event, clr_uart_tx);
        n_tw = upd(tw_flag, twowire_new_state, clr_twowire);
        n_kb = upd(kb_flag, |(keypad_press & keypad_enable),
                   clr_keypad);
        n_cp = upd(cp_flag, capture_event, clr_capture);
        n_bo = upd(bo_flag, brownout_event, clr_brownout);
    end

    isfv_ext_pin u_ext_a (
        .core_clk     (core_clk),
        .srst         (srst),
        .pin_n        (ext_irq_pin_a),
        .mc_en        (mc_tick),
        .trigger_type (ext_a_trigger_type),
        .hw_clear     (hw_clr_a),
        .sw_clear     (clr_ext_a),
        .request_flag (ea_flag)
    );

    isfv_ext_pin u_ext_b (
        .core_clk     (core_clk),
        .srst         (srst),
        .pin_n        (ext_irq_pin_b),
        .mc_en        (mc_tick),
        .trigger_type (ext_b_trigger_type),
        .hw_clear     (hw_clr_b),
        .sw_clear     (clr_ext_b),
        .request_flag (eb_flag)
    );

    // Nesting: stack of in-service levels, one bit per level
    logic [3:0] in_service;
    logic [3:0] next_in_service;

    always_comb
    begin
        req = '0;
        req[SRC_EXT_A]    = ea_flag;
        req[SRC_BROWNOUT] = bo_flag && brownout_irq_select;
        req[SRC_WATCHDOG] = wd_flag;
        req[SRC_TIMER_A]  = ta_flag;
        req[SRC_TWOWIRE]  = tw_flag;
        req[SRC_EXT_B]    = eb_flag;
        req[SRC_KEYPAD]   = kb_flag;
        req[SRC_TIMER_B]  = tb_flag;
        req[SRC_UART]     = rx_flag || tx_flag;
        req[SRC_TIMER_C]  = tc_flag;
        req[SRC_CAPTURE]  = cp_flag;
        req = req & src_enable & {NUM_SRC{global_irq_enable}};
        next_take = 1'b0;
        next_src  = 4'h0;
        next_lvl  = 2'b00;
        // Highest level first, then lowest index within a level
        for (int l = 3; l >= 0; l--)
        begin
            for (int i = NUM_SRC - 1; i >= 0; i--)
            begin
                if (req[i] && src_priority[2*i +: 2] == 2'(l)
                    && !next_take_lvl_found(next_take, next_lvl, 2'(l)))
                begin
                    next_src = 4'(i);
                    next_lvl = 2'(l);
                end
            end
            if (|next_src_hit(req, src_priority, 2'(l)) && !next_take)
                next_take = 1'b1;
        end
        // Only on a poll slot, and only above every level in service
        if (!(mc_tick && cpu_poll_ok) ||
            (|(in_service >> next_lvl)))
            next_take = 1'b0;
        next_in_service = in_service;
        if (cpu_reti)
            for (int l = 3; l >= 0; l--)
                if (next_in_service[l] && in_service == next_in_service)
                    next_in_service[l] = 1'b0;
        if (next_take)
            next_in_service[next_lvl] = 1'b1;
    end

    function automatic logic next_take_lvl_found(input logic t,
        input logic [1:0] cur, input logic [1:0] l);
        next_take_lvl_found = t && cur != l;
    endfunction

    function automatic logic [NUM_SRC-1:0] next_src_hit(
        input logic [NUM_SRC-1:0] r, input logic [2*NUM_SRC-1:0] p,
        input logic [1:0] l);
        for (int i = 0; i < NUM_SRC; i++)
            next_src_hit[i] = r[i] && p[2*i +: 2] == l;
    endfunction

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            mc_cnt <= 8'h00;
            mc_tick <= 1'b0;
            {ta_flag, tb_flag, tc_flag, wd_flag, rx_flag} <= '0;
            {tx_flag, tw_flag, kb_flag, cp_flag, bo_flag} <= '0;
            in_service <= 4'h0;
            irq_take   <= 1'b0;
            irq_source <= 4'h0;
            irq_level  <= 2'b00;
            irq_vector <= 16'h0000;
        end
        else
        begin
            mc_cnt  <= next_mc_cnt;
            mc_tick <= next_mc_tick;
            {ta_flag, tb_flag, tc_flag, wd_flag, rx_flag} <=
                {n_ta, n_tb, n_tc, n_wd, n_rx};
            {tx_flag, tw_flag, kb_flag, cp_flag, bo_flag} <=
                {n_tx, n_tw, n_kb, n_cp, n_bo};
            in_service <= next_in_service;
            irq_take   <= next_take;
            if (next_take)
            begin
                irq_source <= next_src;
                irq_level  <= next_lvl;
                irq_vector <= vec_of(next_src);
            end
        end
    end

    // Flag outputs straight from flip-flops
    always_comb
    begin
        ext_a_request_flag    = ea_flag;
        ext_b_request_flag    = eb_flag;
        timer_a_overflow_flag = ta_flag;
        timer_b_overflow_flag = tb_flag;
        timer_c_event_flag    = tc_flag;
        watchdog_irq_flag     = wd_flag;
        uart_rx_done_flag     = rx_flag;
        uart_tx_done_flag     = tx_flag;
        twowire_irq_flag      = tw_flag;
        keyboard_irq_flag     = kb_flag;
        capture_irq_flag      = cp_flag;
        brownout_flag         = bo_flag;
    end

    chk_timer_hwclr: assert property (@(posedge core_clk) disable iff (srst)
        irq_take && irq_source == SRC_TIMER_A && !timer_a_ovf
        |=> !timer_a_overflow_flag)
        else $error("timer flag not cleared on service");
    chk_timer_c_kept: assert property (@(posedge core_clk) disable iff (srst)
        timer_c_event_flag && !clr_timer_c |=> timer_c_event_flag)
        else $error("timer c flag lost");
    chk_uart_kept: assert property (@(posedge core_clk) disable iff (srst)
        uart_rx_done_flag && !clr_uart_rx |=> uart_rx_done_flag)
        else $error("uart flag lost");
    chk_set_wins: assert property (@(posedge core_clk) disable iff (srst)
        capture_event |=> capture_irq_flag)
        else $error("capture event lost");
    chk_gate_global: assert property (@(posedge core_clk) disable iff (srst)
        !global_irq_enable |=> !irq_take)
        else $error("take while globally disabled");
    chk_take_on_tick: assert property (@(posedge core_clk) disable iff (srst)
        irq_take |-> $past(mc_tick))
        else $error("take off a poll slot");
    chk_vector_map: assert property (@(posedge core_clk) disable iff (srst)
        irq_take && irq_source == SRC_CAPTURE
        |-> irq_vector == 16'h006b)
        else $error("wrong vector");
    chk_brown_gate: assert property (@(posedge core_clk) disable iff (srst)
        irq_take && irq_source == SRC_BROWNOUT
        |-> $past(brownout_irq_select))
        else $error("brownout taken without select");
    chk_keypad_set: assert property (@(posedge core_clk) disable iff (srst)
        |(keypad_press & keypad_enable) |=> keyboard_irq_flag)
        else $error("keypad press lost");
    chk_twowire_set: assert property (@(posedge core_clk) disable iff (srst)
        twowire_new_state |=> twowire_irq_flag)
        else $error("two-wire flag not set");
    chk_wdog_set: assert property (@(posedge core_clk) disable iff (srst)
        watchdog_timeout |=> watchdog_irq_flag)
        else $error("watchdog flag not set");

    cov_take: cover property (@(posedge core_clk) irq_take);
    cov_nest: cover property (@(posedge core_clk)
        irq_take ##[1:50] irq_take && irq_level == 2'b11);
    cov_ext_edge: cover property (@(posedge core_clk)
        irq_take && irq_source == SRC_EXT_A);
    cov_uart: cover property (@(posedge core_clk)
        irq_take && irq_source == SRC_UART);
endmodule : isfv_ctrl
`default_nettype wire

// File: tb/isfv_cpu_model.sv
// CPU core model: poll permission and return-from-service pulse
`timescale 1ns/1ps
`default_nettype none
module isfv_cpu_model
(
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic srst,
    // Bench control and controller answer
    input  wire logic poll_en,
    input  wire logic slow,
    input  wire logic irq_take,
    // Toward the controller
    output logic      cpu_poll_ok,
    output logic      cpu_reti
);
    logic [5:0] cnt;
    assign cpu_poll_ok = poll_en;
    // Short or long service, then one return pulse
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            cnt      <= 6'h0;
            cpu_reti <= 1'b0;
        end
        else
        begin
            cpu_reti <= (cnt == 6'h1);
            if (irq_take)
                cnt <= slow ? 6'h1e : 6'h4;
            else if (cnt != 6'h0)
                cnt <= cnt - 6'h1;
        end
    end
endmodule // isfv_cpu_model
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking testbench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import isfv_pkg::*;
;
    localparam logic [10:0] HW = 11'h0a9;
    logic        core_clk, srst, pin_a, pin_b, trig_a, trig_b, gie, bsel;
    logic        poll_en, slow, tx_ev;
    logic [10:0] ev, en;
    logic [7:0]  kp, kp_en;
    logic [11:0] clr;
    logic [21:0] prio;
    wire logic   take, poll_ok, reti, tick;
    wire logic [15:0] vec;
    wire logic [3:0]  src;
    wire logic [1:0]  lvl;
    wire logic [11:0] fl;
    int          n_fail, num_checks, cycles, n_tick;
    logic [15:0] vt [11] = '{VEC_EXT_A, VEC_BROWNOUT, VEC_WATCHDOG,
        VEC_TIMER_A, VEC_TWOWIRE, VEC_EXT_B, VEC_KEYPAD, VEC_TIMER_B,
        VEC_UART, VEC_TIMER_C, VEC_CAPTURE};

    isfv_ctrl #(.MC_DIV(4)) u_isfv_ctrl (
        .core_clk(core_clk), .srst(srst), .ext_irq_pin_a(pin_a),
        .ext_irq_pin_b(pin_b), .ext_a_trigger_type(trig_a),
        .ext_b_trigger_type(trig_b), .timer_a_ovf(ev[3]),
        .timer_b_ovf(ev[7]), .timer_c_event(ev[9]),
        .watchdog_timeout(ev[2]), .uart_rx_event(ev[8]),
        .uart_tx_event(tx_ev), .twowire_new_state(ev[4]),
        .keypad_press(kp), .capture_event(ev[10]), .brownout_event(ev[1]),
        .clr_ext_a(clr[0]), .clr_ext_b(clr[5]), .clr_timer_a(clr[3]),
        .clr_timer_b(clr[7]), .clr_timer_c(clr[9]), .clr_watchdog(clr[2]),
        .clr_uart_rx(clr[8]), .clr_uart_tx(clr[11]), .clr_twowire(clr[4]),
        .clr_keypad(clr[6]), .clr_capture(clr[10]), .clr_brownout(clr[1]),
        .global_irq_enable(gie), .src_enable(en), .keypad_enable(kp_en),
        .brownout_irq_select(bsel), .src_priority(prio),
        .cpu_poll_ok(poll_ok), .cpu_reti(reti), .irq_take(take),
        .irq_vector(vec), .irq_source(src), .irq_level(lvl), .mc_tick(tick),
        .ext_a_request_flag(fl[0]), .ext_b_request_flag(fl[5]),
        .timer_a_overflow_flag(fl[3]), .timer_b_overflow_flag(fl[7]),
        .timer_c_event_flag(fl[9]), .watchdog_irq_flag(fl[2]),
        .uart_rx_done_flag(fl[8]), .uart_tx_done_flag(fl[11]),
        .twowire_irq_flag(fl[4]), .keyboard_irq_flag(fl[6]),
        .capture_irq_flag(fl[10]), .brownout_flag(fl[1]));

    isfv_cpu_model u_isfv_cpu_model (
        .core_clk(core_clk), .srst(srst), .poll_en(poll_en), .slow(slow),
        .irq_take(take), .cpu_poll_ok(poll_ok), .cpu_reti(reti));

    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            final_report();
        end
    end

    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    function automatic logic flag(input int s);
        return fl[s] | (s == 8 && fl[11]);
    endfunction

    // Pins are held low for whole machine cycles
    task automatic fire(input int s);
        @(negedge core_clk);
        case (s)
            0: pin_a = 1'b0;
            5: pin_b = 1'b0;
            6: kp = 8'h01;
            8: {ev[8], tx_ev} = 2'b11;
            default: ev[s] = 1'b1;
        endcase
        @(negedge core_clk);
        ev = '0;
        kp = 8'h0;
        tx_ev = 1'b0;
    endtask

    task automatic wait_flag(input int s);
        int k;
        k = 0;
        while (flag(s) !== 1'b1 && k < 40)
        begin
            cyc(1);
            k++;
        end
        cmp_bit(flag(s), 1'b1);
    endtask

    task automatic get_take(input logic [3:0] s, input logic [15:0] v);
        int k;
        k = 0;
        while (take !== 1'b1 && k < 200)
        begin
            cyc(1);
            k++;
        end
        cmp_bit(take, 1'b1);
        cmp_word(16'(src), 16'(s));
        cmp_word(vec, v);
    endtask

    task automatic expect_none();
        int c;
        c = 0;
        poll_en = 1'b1;
        repeat (40)
        begin
            cyc(1);
            c += int'(take === 1'b1);
        end
        poll_en = 1'b0;
        cmp_word(16'(c), 16'h0);
    endtask

    task automatic settle();
        poll_en = 1'b0;
        cyc(40);
        pin_a = 1'b1;
        pin_b = 1'b1;
        clr = '1;
        cyc(1);
        clr = '0;
        cyc(12);
    endtask

    initial
    begin
        {pin_a, pin_b, trig_a, trig_b} = {2'b11, TRIG_EDGE, TRIG_EDGE};
        {gie, bsel, poll_en, slow, tx_ev} = 5'b11000;
        {ev, en, kp, clr, prio} = '0;
        kp_en = 8'hff;
        n_fail = 0;
        num_checks = 0;
        cycles = 0;
        srst = 1'b1;
        cyc(6);
        srst = 1'b0;
        cmp_word(16'(fl), 16'h0);
        cmp_bit(take, 1'b0);
        // Machine-cycle tick: one pulse every four clocks
        n_tick = 0;
        repeat (40)
        begin
            cyc(1);
            n_tick += int'(tick === 1'b1);
        end
        cmp_word(16'(n_tick), 16'h000a);
        for (int s = 0; s < NUM_SRC; s++)
        begin
            en = 11'h1 << s;
            fire(s);
            wait_flag(s);
            poll_en = 1'b1;
            get_take(4'(s), vt[s]);
            poll_en = 1'b0;
            cyc(2);
            cmp_bit(flag(s), !HW[s]);
            if (s == 8)
                cmp_bit(fl[11], 1'b1);
            settle();
        end
        // Keypad line gating, global enable, brownout select
        kp_en = 8'hfe;
        en = 11'h040;
        fire(6);
        cyc(12);
        cmp_bit(fl[6], 1'b0);
        en = 11'h010;
        gie = 1'b0;
        fire(4);
        expect_none();
        gie = 1'b1;
        poll_en = 1'b1;
        get_take(SRC_TWOWIRE, VEC_TWOWIRE);
        settle();
        bsel = 1'b0;
        en = 11'h002;
        fire(1);
        expect_none();
        settle();
        // Equal level by rank, then higher level first, slow service
        slow = 1'b1;
        en = 11'h00c;
        fire(2);
        fire(3);
        poll_en = 1'b1;
        get_take(SRC_WATCHDOG, VEC_WATCHDOG);
        cyc(1);
        clr[2] = 1'b1;
        cyc(1);
        clr = '0;
        get_take(SRC_TIMER_A, VEC_TIMER_A);
        settle();
        prio[7:6] = 2'b01;
        fire(2);
        fire(3);
        poll_en = 1'b1;
        get_take(SRC_TIMER_A, VEC_TIMER_A);
        cmp_word(16'(lvl), 16'h1);
        settle();
        // Level mode: flag kept on take, retaken after return
        slow = 1'b0;
        trig_a = TRIG_LEVEL;
        en = 11'h001;
        fire(0);
        poll_en = 1'b1;
        get_take(SRC_EXT_A, VEC_EXT_A);
        cyc(2);
        cmp_bit(fl[0], 1'b1);
        get_take(SRC_EXT_A, VEC_EXT_A);
        settle();
        cmp_bit(fl[0], 1'b0);
        // A short low pulse not taken while polling is off is lost
        pin_a = 1'b0;
        cyc(8);
        pin_a = 1'b1;
        cyc(12);
        expect_none();
        final_report();
    end
endmodule // tb_top
`default_nettype wire
